// *** src/exec_unit.sv ***
// Execution unit: arithmetic, bit, string and program transfer sequencing
`timescale 1ns/100ps
// Function
// - Operands are byte or word binary, or packed/unpacked decimal bytes
// - Every arithmetic result updates the status flags
// - Complement, and, or, exclusive or on bytes or words
// - Test ands the operands, sets flags, writes nothing back
// - Arithmetic and logical shifts repeat single steps, count capped at 32
// - Count comes from the immediate field or the count register low byte
// - Rotates reinsert the leaving bit at the opposite end
// - Rotates through carry use the carry flag as an extra bit
// - Strings of bytes or words, one element per step, up to 64 KB
// - A repeat prefix repeats the string step until termination
// - Repeated strings pause between elements and resume from saved state
// - Source in data segment unless overridden; destination in extra
// - Source index gives source offset, destination index destination
// - Indexes increment when direction flag clear, decrement when set
// - Index step is one for bytes and two for words
// - With a repeat prefix the count drops by one per element
// - Repeat with zero count processes nothing and finishes
// - Code segment and instruction pointer give the next fetch location
// - Any transfer flushes the queue and fetches from the new location
// - Near call pushes the pointer; far call pushes segment and pointer
// - Return restores the continuation from the values the call pushed
// - Unconditional jumps never write the stack
module exec_unit (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_valid,
	input exec_pkg::cmd_s cmd,
	output logic cmd_ready,
	input wire logic init_wr,
	input exec_pkg::arch_s init_val,
	input wire logic intr_pending,
	output logic bus_req,
	output exec_pkg::bus_s bus_cmd,
	input wire logic bus_ack,
	input wire logic [15:0] bus_rdata,
	output logic queue_flush,
	output logic [15:0] fetch_seg,
	output logic [15:0] fetch_ptr,
	output exec_pkg::arch_s arch,
	output logic [15:0] result,
	output logic result_wb,
	output logic done,
	output logic suspended
);
	import exec_pkg::*;
	state_e state, next_state;
	cmd_s cur, next_cur;
	arch_s next_arch;
	bus_s next_bus_cmd;
	logic next_cmd_ready, next_bus_req, next_queue_flush, next_result_wb;
	logic next_done, next_suspended, alu_word, alu_wb;
	logic [15:0] tmp, next_tmp, next_result, next_fetch_seg, next_fetch_ptr;
	logic [15:0] step, alu_a, alu_b, alu_res, sh_res;
	logic [7:0] count_low_byte, sh_count;
	alu_op_e alu_op;
	flags_s alu_flags, sh_flags;
	logic src_used, dst_used, compares, stop, finish, flush;
	function automatic bus_s mk_bus(seg_e s, logic [15:0] off, logic wr,
		logic w, logic io, logic [15:0] d);
		mk_bus = '{seg: s, off: off, write: wr, word: w, io: io, wdata: d};
	endfunction
	function automatic bus_s elem_bus(cmd_s c, arch_s r);
		case (c.str_op)
			STRING_STORE_ACC: elem_bus = mk_bus(SEG_EXTRA, r.dest_index_reg,
				1'b1, c.word, 1'b0, r.acc);
			STRING_SCAN: elem_bus = mk_bus(SEG_EXTRA, r.dest_index_reg,
				1'b0, c.word, 1'b0, RST_WORD);
			STRING_PORT_INPUT: elem_bus = mk_bus(SEG_DATA, c.port,
				1'b0, c.word, 1'b1, RST_WORD);
			default: elem_bus = mk_bus(c.seg_ovr_en ? c.seg_ovr : SEG_DATA,
				r.src_index_reg, 1'b0, c.word, 1'b0, RST_WORD);
		endcase
	endfunction
	function automatic state_e elem_state(str_op_e o);
		case (o)
			STRING_STORE_ACC: elem_state = ST_WRITE;
			STRING_SCAN: elem_state = ST_DST_READ;
			default: elem_state = ST_SRC_READ;
		endcase
	endfunction
	// Index move, wrapping modulo 2^16
	function automatic logic [15:0] adj(logic [15:0] v, logic dec,
		logic [15:0] s);
		adj = dec ? v - s : v + s;
	endfunction

	assign count_low_byte = arch.repeat_count_reg[7:0];
	assign sh_count = cmd.count_from_reg ? count_low_byte
		: cmd.imm_count;

	// Compare step reuses the ALU as a subtract
	assign alu_op = (state == ST_DST_READ) ? ALU_CMP : cmd.alu_op;
	assign alu_word = (state == ST_DST_READ) ? cur.word : cmd.word;
	assign alu_a = (state != ST_DST_READ) ? cmd.opa
		: (cur.str_op == STRING_SCAN) ? arch.acc : tmp;
	assign alu_b = (state == ST_DST_READ) ? bus_rdata : cmd.opb;
	exec_alu u_alu (.op(alu_op), .word(alu_word), .opa(alu_a), .opb(alu_b),
		.flags_in(arch.flags), .result(alu_res), .flags_out(alu_flags),
		.write_back(alu_wb));
	exec_shift u_shift (.op(cmd.shift_op), .word(cmd.word), .value(cmd.opa),
		.count(sh_count), .flags_in(arch.flags), .result(sh_res),
		.flags_out(sh_flags));
	always_comb begin
		next_state = state;
		next_cur = cur;
		next_arch = arch;
		next_bus_cmd = bus_cmd;
		next_bus_req = bus_req && !bus_ack;
		next_tmp = tmp;
		next_result = result;
		next_result_wb = result_wb;
		next_cmd_ready = cmd_ready;
		next_queue_flush = 1'b0;
		next_done = 1'b0;
		next_suspended = 1'b0;
		next_fetch_seg = fetch_seg;
		next_fetch_ptr = fetch_ptr;
		finish = 1'b0;
		flush = 1'b0;
		stop = 1'b0;
		step = cur.word ? STEP_WORD : STEP_BYTE;
		compares = (cur.str_op == STRING_COMPARE)
			|| (cur.str_op == STRING_SCAN);
		src_used = (cur.str_op == STRING_MOVE) || (cur.str_op == STRING_COMPARE)
			|| (cur.str_op == STRING_LOAD_ACC)
			|| (cur.str_op == STRING_PORT_OUTPUT);
		dst_used = (cur.str_op != STRING_LOAD_ACC)
			&& (cur.str_op != STRING_PORT_OUTPUT);
		case (state)
			ST_IDLE: begin
				if (init_wr) begin
					next_arch = init_val;
				end
				if (cmd_valid && cmd_ready) begin
					next_cur = cmd;
					case (cmd.group)
						GRP_ALU: begin
							next_result = alu_res;
							next_result_wb = alu_wb;
							next_arch.flags = alu_flags;
							finish = 1'b1;
						end
						GRP_SHIFT: begin
							next_result = sh_res;
							next_result_wb = 1'b1;
							next_arch.flags = sh_flags;
							finish = 1'b1;
						end
						GRP_STRING: begin
							if ((cmd.rep != REPEAT_NONE)
								&& (arch.repeat_count_reg == RST_WORD)) begin
								finish = 1'b1;
							end else begin
								next_bus_req = 1'b1;
								next_bus_cmd = elem_bus(cmd, next_arch);
								next_state = elem_state(cmd.str_op);
								next_cmd_ready = 1'b0;
							end
						end
						default: begin
							case (cmd.xfer)
								NEAR_CALL, FAR_CALL: begin
									next_arch.stack_ptr = arch.stack_ptr - STEP_WORD;
									next_bus_req = 1'b1;
									next_bus_cmd = mk_bus(SEG_STACK,
										next_arch.stack_ptr, 1'b1, 1'b1, 1'b0,
										(cmd.xfer == FAR_CALL) ? arch.code_seg
										: arch.instruction_pointer);
									next_state = (cmd.xfer == FAR_CALL)
										? ST_PUSH_SEG : ST_PUSH_PTR;
									next_cmd_ready = 1'b0;
								end
								NEAR_RETURN, FAR_RETURN: begin
									next_bus_req = 1'b1;
									next_bus_cmd = mk_bus(SEG_STACK, arch.stack_ptr,
										1'b0, 1'b1, 1'b0, RST_WORD);
									next_state = ST_POP_PTR;
									next_cmd_ready = 1'b0;
								end
								default: begin
									next_arch.instruction_pointer = cmd.target_ptr;
									if (cmd.xfer == FAR_UNCONDITIONAL_JUMP) begin
										next_arch.code_seg = cmd.target_seg;
									end
									flush = 1'b1;
								end
							endcase
						end
					endcase
				end
			end
			ST_SRC_READ: begin
				if (bus_ack) begin
					next_tmp = bus_rdata;
					next_bus_req = 1'b1;
					next_state = ST_WRITE;
					case (cur.str_op)
						STRING_LOAD_ACC: begin
							next_bus_req = 1'b0;
							next_arch.acc = cur.word ? bus_rdata
								: {arch.acc[15:8], bus_rdata[7:0]};
							next_state = ST_STEP;
						end
						STRING_COMPARE: begin
							next_bus_cmd = mk_bus(SEG_EXTRA, arch.dest_index_reg,
								1'b0, cur.word, 1'b0, RST_WORD);
							next_state = ST_DST_READ;
						end
						STRING_PORT_OUTPUT: next_bus_cmd = mk_bus(SEG_DATA,
							cur.port, 1'b1, cur.word, 1'b1, bus_rdata);
						default: next_bus_cmd = mk_bus(SEG_EXTRA,
							arch.dest_index_reg, 1'b1, cur.word, 1'b0,
							bus_rdata);
					endcase
				end
			end
			ST_DST_READ: begin
				if (bus_ack) begin
					next_arch.flags = alu_flags;
					next_state = ST_STEP;
				end
			end
			ST_WRITE: begin
				if (bus_ack) begin
					next_state = ST_STEP;
				end
			end
			ST_STEP: begin
				if (src_used) begin
					next_arch.src_index_reg = adj(arch.src_index_reg,
						arch.flags.direction_flag, step);
				end
				if (dst_used) begin
					next_arch.dest_index_reg = adj(arch.dest_index_reg,
						arch.flags.direction_flag, step);
				end
				if (cur.rep != REPEAT_NONE) begin
					next_arch.repeat_count_reg = adj(arch.repeat_count_reg,
						1'b1, STEP_BYTE);
				end
				stop = (cur.rep == REPEAT_NONE)
					|| (next_arch.repeat_count_reg == RST_WORD)
					|| (compares && ((cur.rep == REPEAT_WHILE_EQUAL_PREFIX)
					== !arch.flags.zero));
				if (stop) begin
					finish = 1'b1;
				end else if (intr_pending) begin
					next_suspended = 1'b1;
					next_state = ST_IDLE;
					next_cmd_ready = 1'b1;
				end else begin
					next_bus_req = 1'b1;
					next_bus_cmd = elem_bus(cur, next_arch);
					next_state = elem_state(cur.str_op);
				end
			end
			ST_PUSH_SEG: begin
				if (bus_ack) begin
					next_arch.stack_ptr = arch.stack_ptr - STEP_WORD;
					next_bus_req = 1'b1;
					next_bus_cmd = mk_bus(SEG_STACK, next_arch.stack_ptr, 1'b1,
						1'b1, 1'b0, arch.instruction_pointer);
					next_state = ST_PUSH_PTR;
				end
			end
			ST_PUSH_PTR: begin
				if (bus_ack) begin
					next_arch.instruction_pointer = cur.target_ptr;
					if (cur.xfer == FAR_CALL) begin
						next_arch.code_seg = cur.target_seg;
					end
					flush = 1'b1;
				end
			end
			ST_POP_PTR: begin
				if (bus_ack) begin
					next_arch.instruction_pointer = bus_rdata;
					next_arch.stack_ptr = arch.stack_ptr + STEP_WORD;
					if (cur.xfer == FAR_RETURN) begin
						next_bus_req = 1'b1;
						next_bus_cmd = mk_bus(SEG_STACK, next_arch.stack_ptr,
							1'b0, 1'b1, 1'b0, RST_WORD);
						next_state = ST_POP_SEG;
					end else begin
						flush = 1'b1;
					end
				end
			end
			ST_POP_SEG: begin
				if (bus_ack) begin
					next_arch.code_seg = bus_rdata;
					next_arch.stack_ptr = arch.stack_ptr + STEP_WORD;
					flush = 1'b1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cmd_ready = 1'b1;
			end
		endcase
		if (flush) begin
			next_queue_flush = 1'b1;
			next_fetch_seg = next_arch.code_seg;
			next_fetch_ptr = next_arch.instruction_pointer;
		end
		if (finish || flush) begin
			next_done = 1'b1;
			next_state = ST_IDLE;
			next_cmd_ready = 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cur <= '0;
			arch <= '0;
			bus_cmd <= '0;
			cmd_ready <= 1'b1;
			{bus_req, result_wb, queue_flush, done, suspended} <= 5'h00;
			{tmp, result, fetch_seg, fetch_ptr} <= {4{RST_WORD}};
		end else begin
			state <= next_state;
			cur <= next_cur;
			arch <= next_arch;
			bus_cmd <= next_bus_cmd;
			cmd_ready <= next_cmd_ready;
			{bus_req, result_wb} <= {next_bus_req, next_result_wb};
			{queue_flush, done, suspended} <= {next_queue_flush, next_done,
				next_suspended};
			{tmp, result} <= {next_tmp, next_result};
			{fetch_seg, fetch_ptr} <= {next_fetch_seg, next_fetch_ptr};
		end
	end
endmodule

// *** pkg/exec_pkg.sv ***
// Shared types, constants and helpers for the execution unit
package exec_pkg;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] STEP_BYTE = 16'h0001;
	localparam logic [15:0] STEP_WORD = 16'h0002;
	localparam logic [7:0] SHIFT_MAX = 8'h20;
	localparam logic [3:0] DEC_DIGIT_MAX = 4'h9;
	localparam logic [7:0] DEC_PAIR_MAX = 8'h99;
	localparam logic [7:0] DEC_ADJ_LO = 8'h06;
	localparam logic [7:0] DEC_ADJ_HI = 8'h60;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB, ALU_CMP, ALU_AND, ALU_OR,
		ALU_XOR, ALU_NOT, ALU_TEST, ALU_DEC_ADJ, ALU_ASCII_ADJ
	} alu_op_e;
	typedef enum logic [2:0] {
		SHIFT_LEFT, SHIFT_RIGHT_LOGICAL, SHIFT_RIGHT_ARITH, ROTATE_LEFT,
		ROTATE_RIGHT, ROTATE_LEFT_THRU_CARRY, ROTATE_RIGHT_THRU_CARRY
	} shift_op_e;
	typedef enum logic [2:0] {
		STRING_MOVE, STRING_COMPARE, STRING_SCAN, STRING_LOAD_ACC,
		STRING_STORE_ACC, STRING_PORT_INPUT, STRING_PORT_OUTPUT
	} str_op_e;
	typedef enum logic [1:0] {
		REPEAT_NONE, REPEAT_WHILE_EQUAL_PREFIX, REPEAT_WHILE_UNEQUAL_PREFIX
	} rep_e;
	typedef enum logic [2:0] {
		NEAR_CALL, FAR_CALL, NEAR_RETURN, FAR_RETURN,
		NEAR_UNCONDITIONAL_JUMP, FAR_UNCONDITIONAL_JUMP
	} xfer_e;
	typedef enum logic [1:0] {GRP_ALU, GRP_SHIFT, GRP_STRING, GRP_XFER} group_e;
	typedef enum logic [1:0] {SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA} seg_e;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001, ST_SRC_READ = 9'h002, ST_DST_READ = 9'h004,
		ST_WRITE = 9'h008, ST_STEP = 9'h010, ST_PUSH_SEG = 9'h020,
		ST_PUSH_PTR = 9'h040, ST_POP_PTR = 9'h080, ST_POP_SEG = 9'h100
	} state_e;

	typedef struct packed {
		logic overflow;
		logic direction_flag;
		logic sign;
		logic zero;
		logic aux;
		logic parity;
		logic carry_flag;
	} flags_s;

	typedef struct packed {
		group_e group;
		alu_op_e alu_op;
		shift_op_e shift_op;
		str_op_e str_op;
		xfer_e xfer;
		rep_e rep;
		logic word;
		logic seg_ovr_en;
		seg_e seg_ovr;
		logic count_from_reg;
		logic [7:0] imm_count;
		logic [15:0] opa;
		logic [15:0] opb;
		logic [15:0] port;
		logic [15:0] target_ptr;
		logic [15:0] target_seg;
	} cmd_s;

	typedef struct packed {
		logic [15:0] src_index_reg;
		logic [15:0] dest_index_reg;
		logic [15:0] repeat_count_reg;
		logic [15:0] stack_ptr;
		logic [15:0] instruction_pointer;
		logic [15:0] code_seg;
		logic [15:0] acc;
		flags_s flags;
	} arch_s;

	typedef struct packed {
		seg_e seg;
		logic [15:0] off;
		logic write;
		logic word;
		logic io;
		logic [15:0] wdata;
	} bus_s;

	function automatic logic msb(logic word, logic [15:0] v);
		msb = word ? v[15] : v[7];
	endfunction

	function automatic flags_s set_szp(flags_s f, logic word, logic [15:0] r);
		set_szp = f;
		set_szp.sign = msb(word, r);
		set_szp.zero = word ? (r == RST_WORD) : (r[7:0] == RST_WORD[7:0]);
		set_szp.parity = ~^r[7:0];
	endfunction
endpackage

// *** src/exec_alu.sv ***
// Binary, decimal and logical operations with flag generation
`timescale 1ns/100ps
module exec_alu (
	input exec_pkg::alu_op_e op,
	input wire logic word,
	input wire logic [15:0] opa,
	input wire logic [15:0] opb,
	input exec_pkg::flags_s flags_in,
	output logic [15:0] result,
	output exec_pkg::flags_s flags_out,
	output logic write_back
);
	import exec_pkg::*;
	logic [16:0] sum;
	logic [15:0] b_eff;
	logic sub;
	logic cin;
	logic lo_fix;

	always_comb begin
		sub = (op == ALU_SUB) || (op == ALU_SBB) || (op == ALU_CMP);
		cin = ((op == ALU_ADC) || (op == ALU_SBB)) && flags_in.carry_flag;
		b_eff = sub ? ~opb : opb;
		sum = {1'b0, opa} + {1'b0, b_eff} + {16'h0000, cin ^ sub};
		result = sum[15:0];
		write_back = 1'b1;
		flags_out = flags_in;
		lo_fix = (opa[3:0] > DEC_DIGIT_MAX) || flags_in.aux;
		case (op)
			ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBB, ALU_CMP: begin
				write_back = (op != ALU_CMP);
				flags_out = set_szp(flags_in, word, sum[15:0]);
				flags_out.carry_flag = sub ^ (word ? sum[16]
					: (opa[8] ^ b_eff[8] ^ sum[8]));
				flags_out.aux = sub ^ opa[4] ^ b_eff[4] ^ sum[4];
				flags_out.overflow = (msb(word, opa) == msb(word, b_eff))
					&& (msb(word, sum[15:0]) != msb(word, opa));
			end
			ALU_AND, ALU_OR, ALU_XOR, ALU_TEST: begin
				case (op)
					ALU_OR: result = opa | opb;
					ALU_XOR: result = opa ^ opb;
					default: result = opa & opb;
				endcase
				write_back = (op != ALU_TEST);
				flags_out = set_szp(flags_in, word, result);
				flags_out.carry_flag = 1'b0;
				flags_out.overflow = 1'b0;
			end
			ALU_NOT: result = ~opa;
			ALU_DEC_ADJ: begin
				// Packed decimal, two digits in the low byte
				result = opa;
				if (lo_fix) begin
					result[7:0] = opa[7:0] + DEC_ADJ_LO;
				end
				flags_out.carry_flag = (opa[7:0] > DEC_PAIR_MAX)
					|| flags_in.carry_flag;
				if (flags_out.carry_flag) begin
					result[7:0] = result[7:0] + DEC_ADJ_HI;
				end
				flags_out = set_szp(flags_out, 1'b0, result);
				flags_out.aux = lo_fix;
			end
			ALU_ASCII_ADJ: begin
				// Unpacked decimal, one digit per byte
				if (lo_fix) begin
					result = {opa[15:8] + STEP_BYTE[7:0], 4'h0,
						opa[3:0] + DEC_ADJ_LO[3:0]};
				end else begin
					result = {opa[15:8], 4'h0, opa[3:0]};
				end
				flags_out.aux = lo_fix;
				flags_out.carry_flag = lo_fix;
			end
			default: write_back = 1'b0;
		endcase
	end
endmodule

// *** src/exec_shift.sv ***
// Shift and rotate unit, one bit position per loop step
`timescale 1ns/100ps
module exec_shift (
	input exec_pkg::shift_op_e op,
	input wire logic word,
	input wire logic [15:0] value,
	input wire logic [7:0] count,
	input exec_pkg::flags_s flags_in,
	output logic [15:0] result,
	output exec_pkg::flags_s flags_out
);
	import exec_pkg::*;
	logic [15:0] v;
	logic [7:0] n;
	logic c;
	logic nb;
	logic top;

	function automatic logic [15:0] put_top(logic w, logic [15:0] x, logic b);
		put_top = w ? {b, x[14:0]} : {8'h00, b, x[6:0]};
	endfunction

	always_comb begin
		v = value;
		c = flags_in.carry_flag;
		nb = 1'b0;
		top = 1'b0;
		n = (count > SHIFT_MAX) ? SHIFT_MAX : count;
		for (int i = 0; i < int'(SHIFT_MAX); i++) begin
			if (8'(i) < n) begin
				top = msb(word, v);
				nb = c;
				case (op)
					SHIFT_LEFT: begin
						c = top;
						v = v << 1;
					end
					ROTATE_LEFT: begin
						c = top;
						v = {v[14:0], top};
					end
					ROTATE_LEFT_THRU_CARRY: begin
						c = top;
						v = {v[14:0], nb};
					end
					SHIFT_RIGHT_LOGICAL: begin
						c = v[0];
						v = put_top(word, v >> 1, 1'b0);
					end
					SHIFT_RIGHT_ARITH: begin
						c = v[0];
						v = put_top(word, v >> 1, top);
					end
					ROTATE_RIGHT: begin
						c = v[0];
						v = put_top(word, v >> 1, v[0]);
					end
					default: begin
						c = v[0];
						v = put_top(word, v >> 1, nb);
					end
				endcase
			end
		end
		result = word ? v : {8'h00, v[7:0]};
		flags_out = flags_in;
		if (n != 8'h00) begin
			flags_out.carry_flag = c;
			case (op)
				SHIFT_LEFT, ROTATE_LEFT, ROTATE_LEFT_THRU_CARRY:
					flags_out.overflow = msb(word, result) ^ c;
				SHIFT_RIGHT_LOGICAL: flags_out.overflow = msb(word, value);
				SHIFT_RIGHT_ARITH: flags_out.overflow = 1'b0;
				default: flags_out.overflow = msb(word, result)
					^ (word ? result[14] : result[6]);
			endcase
			if ((op == SHIFT_LEFT) || (op == SHIFT_RIGHT_LOGICAL)
				|| (op == SHIFT_RIGHT_ARITH)) begin
				flags_out = set_szp(flags_out, word, result);
			end
		end
	end
endmodule

// *** tb/exec_unit_sva.sv ***
// Port checker for the execution unit
`timescale 1ns/100ps
module exec_unit_sva (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmd_valid,
	input exec_pkg::cmd_s cmd,
	input wire logic cmd_ready,
	input wire logic init_wr,
	input exec_pkg::arch_s arch,
	input wire logic bus_req,
	input exec_pkg::bus_s bus_cmd,
	input wire logic bus_ack,
	input wire logic queue_flush,
	input wire logic [15:0] fetch_seg,
	input wire logic [15:0] fetch_ptr,
	input wire logic [15:0] result,
	input wire logic result_wb,
	input wire logic done
);
	import exec_pkg::*;
	logic take;
	assign take = cmd_valid && cmd_ready;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	a_bus_held: assert property (bus_req && !bus_ack |=>
		bus_req && $stable(bus_cmd))
		else $error("bus request dropped before ack");
	a_alu_done: assert property (take && cmd.group == GRP_ALU |=> done)
		else $error("alu command did not finish in one cycle");
	a_test_nowb: assert property (take && cmd.group == GRP_ALU &&
		cmd.alu_op == ALU_TEST |=> !result_wb)
		else $error("test op asked for write back");
	a_and_value: assert property (take && cmd.group == GRP_ALU &&
		cmd.alu_op == ALU_AND |=>
		result[7:0] == ($past(cmd.opa[7:0]) & $past(cmd.opb[7:0])))
		else $error("and result wrong");
	a_jump_nostack: assert property (take && cmd.group == GRP_XFER &&
		(cmd.xfer == NEAR_UNCONDITIONAL_JUMP ||
		cmd.xfer == FAR_UNCONDITIONAL_JUMP) |=>
		done && queue_flush && !bus_req)
		else $error("jump touched the bus or did not flush");
	a_flush_loc: assert property (queue_flush |->
		fetch_ptr == arch.instruction_pointer && fetch_seg == arch.code_seg)
		else $error("fetch location differs from pointer");
	a_zero_rep: assert property (take && !init_wr &&
		cmd.group == GRP_STRING && cmd.rep != REPEAT_NONE &&
		arch.repeat_count_reg == 16'h0000 |=> done && !bus_req)
		else $error("zero count repeat did work");
	a_dest_extra: assert property (bus_req && bus_cmd.write &&
		!bus_cmd.io && bus_cmd.seg != SEG_STACK |-> bus_cmd.seg == SEG_EXTRA)
		else $error("string write outside extra segment");
	a_rot_full: assert property (take && cmd.group == GRP_SHIFT &&
		cmd.shift_op == ROTATE_LEFT && cmd.word && !cmd.count_from_reg &&
		cmd.imm_count == 8'h10 |=> result == $past(cmd.opa))
		else $error("full rotate lost bits");
	c_string: cover property (take && cmd.group == GRP_STRING);
	c_flush: cover property (queue_flush);
	c_stack: cover property (bus_ack && bus_cmd.seg == SEG_STACK);
endmodule

// *** tb/biu_model.sv ***
// Bus unit model: byte memory, stack and port answers
`timescale 1ns/100ps
module biu_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] lat,
	input wire logic bus_req,
	input exec_pkg::bus_s bus_cmd,
	output logic bus_ack,
	output logic [15:0] bus_rdata
);
	import exec_pkg::*;
	logic [7:0] mem [0:255];
	logic [3:0] wait_cnt;
	logic [7:0] a;
	logic go;
	assign a = bus_cmd.off[7:0];
	assign go = bus_req && !bus_ack && wait_cnt >= lat;
	always @(posedge mclk) begin
		if (go && bus_cmd.write && !bus_cmd.io) begin
			mem[a] <= bus_cmd.wdata[7:0];
			if (bus_cmd.word)
				mem[a + 8'h01] <= bus_cmd.wdata[15:8];
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus_ack <= 1'b0;
			wait_cnt <= 4'h0;
			bus_rdata <= 16'h5A5A;
		end else begin
			bus_ack <= go;
			wait_cnt <= (bus_req && !go && !bus_ack) ? wait_cnt + 4'h1 : 4'h0;
			// Idle data turns over so stale reads show
			bus_rdata <= go ? (bus_cmd.io ? ~bus_cmd.off :
				{mem[a + 8'h01], mem[a]}) : ~bus_rdata;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the execution unit
`timescale 1ns/100ps
module tb_top;
	import exec_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	cmd_s cmd = '0;
	logic init_wr = 1'b0;
	arch_s init_val = '0;
	logic intr_pending = 1'b0;
	logic [3:0] lat = 4'h0;
	logic cmd_ready, bus_req, bus_ack, queue_flush, result_wb, done, suspended;
	bus_s bus_cmd;
	logic [15:0] bus_rdata, fetch_seg, fetch_ptr, result;
	arch_s arch;
	cmd_s c;
	int n_errors = 0;
	int total_checks = 0;

	always #10 mclk = ~mclk;

	exec_unit dut (.mclk, .rst, .cmd_valid, .cmd, .cmd_ready, .init_wr,
		.init_val, .intr_pending, .bus_req, .bus_cmd, .bus_ack, .bus_rdata,
		.queue_flush, .fetch_seg, .fetch_ptr, .arch, .result, .result_wb,
		.done, .suspended);
	biu_model bfm (.mclk, .rst, .lat, .bus_req, .bus_cmd, .bus_ack,
		.bus_rdata);

	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic setup(input arch_s v);
		@(negedge mclk);
		init_val = v;
		init_wr = 1'b1;
		@(negedge mclk);
		init_wr = 1'b0;
	endtask

	task automatic run();
		int n;
		n = 0;
		@(negedge mclk);
		cmd = c;
		cmd_valid = 1'b1;
		@(negedge mclk);
		cmd_valid = 1'b0;
		while (done !== 1'b1 && suspended !== 1'b1 && n < 100) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 100, "no completion");
	endtask

	task automatic t_logic();
		alu_op_e ops[4] = '{ALU_AND, ALU_OR, ALU_XOR, ALU_NOT};
		logic [15:0] ex[4] = '{16'h3030, 16'hFCFC, 16'hCCCC, 16'h0F0F};
		c = '0;
		c.group = GRP_ALU;
		c.word = 1'b1;
		c.opa = 16'hF0F0;
		c.opb = 16'h3C3C;
		for (int i = 0; i < 4; i++) begin
			c.alu_op = ops[i];
			run();
			chk(result === ex[i] && result_wb === 1'b1, "logic op");
		end
		c.alu_op = ALU_TEST;
		c.opb = 16'h0F0F;
		run();
		chk(result_wb === 1'b0 && arch.flags.zero === 1'b1, "test op");
		c.alu_op = ALU_ADD;
		c.opa = 16'hFFFF;
		c.opb = 16'h0001;
		run();
		chk(result === 16'h0000 && arch.flags.carry_flag === 1'b1 &&
			arch.flags.zero === 1'b1, "add flags");
		c.word = 1'b0;
		c.opa = 16'h0038;
		c.opb = 16'h0045;
		run();
		c.alu_op = ALU_DEC_ADJ;
		c.opa = 16'h007D;
		run();
		chk(result[7:0] === 8'h83 && arch.flags.carry_flag === 1'b0,
			"decimal adjust");
	endtask

	task automatic t_shift();
		shift_op_e ops[7] = '{SHIFT_LEFT, SHIFT_RIGHT_LOGICAL,
			SHIFT_RIGHT_ARITH, ROTATE_LEFT, ROTATE_RIGHT,
			ROTATE_LEFT_THRU_CARRY, ROTATE_RIGHT_THRU_CARRY};
		logic [7:0] ex[7] = '{8'h02, 8'h40, 8'hC0, 8'h03, 8'hC0, 8'h02, 8'h40};
		arch_s v;
		v = '0;
		v.repeat_count_reg = 16'h0104;
		c = '0;
		c.group = GRP_SHIFT;
		c.opa = 16'h0081;
		c.imm_count = 8'h01;
		for (int i = 0; i < 7; i++) begin
			setup(v);
			c.shift_op = ops[i];
			run();
			chk(result[7:0] === ex[i] && arch.flags.carry_flag === 1'b1,
				"shift op");
		end
		c.shift_op = SHIFT_RIGHT_ARITH;
		c.word = 1'b1;
		c.opa = 16'h8000;
		c.count_from_reg = 1'b1;
		run();
		chk(result === 16'hF800, "count from register");
		c.shift_op = ROTATE_LEFT;
		c.count_from_reg = 1'b0;
		c.opa = 16'h1234;
		c.imm_count = 8'h10;
		run();
		chk(result === 16'h1234, "rotate by width");
	endtask

	task automatic t_string();
		arch_s v;
		v = '0;
		v.src_index_reg = 16'h0010;
		v.dest_index_reg = 16'h0030;
		v.repeat_count_reg = 16'h0002;
		v.flags.direction_flag = 1'b1;
		for (int i = 0; i < 256; i++)
			bfm.mem[i] = i[7:0];
		setup(v);
		lat = 4'h2;
		intr_pending = 1'b1;
		c = '0;
		c.group = GRP_STRING;
		c.str_op = STRING_MOVE;
		c.rep = REPEAT_WHILE_EQUAL_PREFIX;
		c.word = 1'b1;
		run();
		chk(suspended === 1'b1 && arch.repeat_count_reg === 16'h0001 &&
			arch.src_index_reg === 16'h000E, "pause");
		intr_pending = 1'b0;
		run();
		chk(done === 1'b1 && arch.dest_index_reg === 16'h002C &&
			arch.repeat_count_reg === 16'h0000, "resume");
		chk({bfm.mem[8'h31], bfm.mem[8'h30], bfm.mem[8'h2F],
			bfm.mem[8'h2E]} === 32'h11100F0E, "moved data");
		lat = 4'h0;
		run();
		chk(done === 1'b1 && arch.src_index_reg === 16'h000C,
			"zero count");
		v = '0;
		v.dest_index_reg = 16'hFFFE;
		v.repeat_count_reg = 16'h0005;
		v.acc = 16'h0001;
		setup(v);
		c.str_op = STRING_SCAN;
		c.rep = REPEAT_WHILE_UNEQUAL_PREFIX;
		c.word = 1'b0;
		run();
		chk(done === 1'b1 && arch.dest_index_reg === 16'h0002 &&
			arch.repeat_count_reg === 16'h0001 && arch.flags.zero === 1'b1,
			"scan match");
	endtask

	task automatic t_xfer();
		arch_s v;
		v = '0;
		v.stack_ptr = 16'h0080;
		v.instruction_pointer = 16'h1234;
		v.code_seg = 16'h5678;
		setup(v);
		c = '0;
		c.group = GRP_XFER;
		c.xfer = FAR_CALL;
		c.target_ptr = 16'h0100;
		c.target_seg = 16'h0200;
		run();
		chk(queue_flush === 1'b1 && fetch_ptr === 16'h0100 &&
			fetch_seg === 16'h0200, "call flush");
		chk(arch.stack_ptr === 16'h007C && {bfm.mem[8'h7F], bfm.mem[8'h7E],
			bfm.mem[8'h7D], bfm.mem[8'h7C]} === 32'h56781234, "call");
		c.xfer = NEAR_UNCONDITIONAL_JUMP;
		c.target_ptr = 16'h0300;
		run();
		chk(arch.stack_ptr === 16'h007C && queue_flush === 1'b1 &&
			arch.instruction_pointer === 16'h0300, "jump");
		c.xfer = FAR_RETURN;
		run();
		chk(arch.instruction_pointer === 16'h1234 && arch.code_seg ===
			16'h5678 && arch.stack_ptr === 16'h0080, "return");
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		chk(cmd_ready === 1'b1 && arch === '0 && bus_req === 1'b0, "reset");
		t_logic();
		t_shift();
		t_string();
		t_xfer();
		end_sim();
	end

	initial begin
		#100us;
		n_errors++;
		end_sim();
	end
endmodule

bind exec_unit exec_unit_sva chk_i (.mclk, .rst, .cmd_valid, .cmd,
	.cmd_ready, .init_wr, .arch, .bus_req, .bus_cmd, .bus_ack, .queue_flush,
	.fetch_seg, .fetch_ptr, .result, .result_wb, .done);
